// >>> common/supervisor_regs.svh
// supervisor constants: offsets, fields, timing counts
// assumes a 25 MHz hclk; times convert to cycles here
// What this block does
// [R1] hold reset for hold-off after supply returns
// [R2] assert reset while supply below threshold
// [R3] manual reset asserts reset, disables watchdog
// [R4] reset asserted disables watchdog, ignores kicks
// [R5] host holds level changes at least 1 us
// [R6] guard low disables watchdog, ignores kicks
// [R7] disabled watchdog leaves timeout flag released
// [R8] guard high runs watchdog, may change anytime
// [R9] ignore kicks for settle time after enabling
// [R10] only falling kick edges service the watchdog
// [R11] host kick pulses at least 50 ns wide
// [R12] first kick only before close time
// [R13] later kicks inside open..close window else fault
// [R14] floating select: 800 ms open, 1600 ms close
// [R15] resistor select: 1.85 ms open, 11 ms close
// [R16] probe select pin after reset, within 381 us
// [R17] startup: ignore supply for 300 us first
// [R18] timeout flag low for hold-off, then released
// [R19] reset asserted forces timeout flag released
// [R20] kicks ignored while timeout flag low
// [R21] capacitor mode: comparator close, open half
// [R22] synchronise all asynchronous inputs first
`ifndef SUPERVISOR_REGS_SVH
`define SUPERVISOR_REGS_SVH

// ============
// clock
`define CLK_MHZ 25
`define CLK_PERIOD_NS 40

// ============
// times in their own units
`define HOLDOFF_US 200000
`define STARTUP_US 300
`define SETTLE_US 150
`define PROBE_US 381
`define FLOAT_OPEN_US 800000
`define FLOAT_CLOSE_US 1600000
`define RES_OPEN_NS 1850000
`define RES_CLOSE_US 11000
`define LEVEL_HOLD_NS 1000
`define KICK_LOW_NS 50
`define DISCH_NS 1000

// ============
// derived cycle counts (least times round up)
`define HOLDOFF_CYC (`HOLDOFF_US * `CLK_MHZ)
`define STARTUP_CYC (`STARTUP_US * `CLK_MHZ)
`define SETTLE_CYC (`SETTLE_US * `CLK_MHZ)
`define PROBE_CYC (`PROBE_US * `CLK_MHZ)
`define FLOAT_OPEN_CYC (`FLOAT_OPEN_US * `CLK_MHZ)
`define FLOAT_CLOSE_CYC (`FLOAT_CLOSE_US * `CLK_MHZ)
`define RES_OPEN_CYC (`RES_OPEN_NS / `CLK_PERIOD_NS)
`define RES_CLOSE_CYC (`RES_CLOSE_US * `CLK_MHZ)
`define LEVEL_HOLD_CYC ((`LEVEL_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define KICK_LOW_CYC ((`KICK_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DISCH_CYC ((`DISCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SENSE_SAMPLE_CYC 4

// ============
// host register map and fields
`define CTRL_OFS 8'h00
`define KICK_OFS 8'h04
`define STAT_OFS 8'h08
`define CTRL_MAN_BIT 0
`define CTRL_EN_BIT 1
`define KICK_GO_BIT 0
`define CTRL_RST 2'b00

// ============
// synchroniser reset levels: manual high, guard low, kick high
`define SYNC_INIT 8'h05

`endif

// >>> common/supervisor_pkg.sv
// types shared by both ends of the supervisor link
// assumes the constants header is included by whoever needs numbers
package supervisor_pkg;

    typedef enum logic [3:0] {
        SUP_START = 4'b0001,
        SUP_LOW = 4'b0010,
        SUP_HOLD = 4'b0100,
        SUP_RUN = 4'b1000
    } sup_state_e;

    typedef enum logic [4:0] {
        WD_OFF = 5'b00001,
        WD_SETTLE = 5'b00010,
        WD_FIRST = 5'b00100,
        WD_WINDOW = 5'b01000,
        WD_FAULT = 5'b10000
    } wd_state_e;

    typedef enum logic [3:0] {
        PR_IDLE = 4'b0001,
        PR_DISCH = 4'b0010,
        PR_SENSE = 4'b0100,
        PR_DONE = 4'b1000
    } probe_state_e;

    typedef enum logic [1:0] {
        MODE_FLOAT = 2'b00,
        MODE_RES = 2'b01,
        MODE_CAP = 2'b10
    } win_mode_e;

endpackage

// >>> common/supervisor_if.sv
// pins between the supervisor and the host that services it
// open-drain outputs resolve here with an implied pullup
`timescale 1ns/1ps
interface supervisor_if;
    // host to device
    logic manual_reset_n;
    logic guard_enable;
    logic service_kick_in;
    // device open-drain drivers
    logic reset_o;
    logic reset_oe;
    logic flag_o;
    logic flag_oe;
    // resolved lines, pulled high when nobody drives
    logic reset_line;
    logic timeout_flag_n;

    assign reset_line = reset_oe ? reset_o : 1'b1;
    assign timeout_flag_n = flag_oe ? flag_o : 1'b1;

    modport dev (
        input manual_reset_n,
        input guard_enable,
        input service_kick_in,
        output reset_o,
        output reset_oe,
        output flag_o,
        output flag_oe
    );

    modport host (
        output manual_reset_n,
        output guard_enable,
        output service_kick_in,
        input reset_line,
        input timeout_flag_n
    );
endinterface

// >>> src/supervisor_dev.sv
// device end: reset sequencer, window-select probe and window watchdog
// assumes comparators and pin sense arrive as async levels
`timescale 1ns/1ps
`include "supervisor_regs.svh"
module supervisor_dev
    import supervisor_pkg::*;
#(
    parameter int unsigned HOLDOFF_CYC = `HOLDOFF_CYC,
    parameter int unsigned STARTUP_CYC = `STARTUP_CYC,
    parameter int unsigned PROBE_CYC = `PROBE_CYC,
    parameter int unsigned FLOAT_OPEN_CYC = `FLOAT_OPEN_CYC,
    parameter int unsigned FLOAT_CLOSE_CYC = `FLOAT_CLOSE_CYC,
    parameter int unsigned RES_OPEN_CYC = `RES_OPEN_CYC,
    parameter int unsigned RES_CLOSE_CYC = `RES_CLOSE_CYC
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // link to the host
    supervisor_if.dev link,
    // supply comparators
    input wire logic below_threshold,
    input wire logic above_release,
    input wire logic lockout_ok,
    // window select pin and its comparator
    input wire logic window_select_in,
    output logic window_select_out,
    output logic window_select_oe,
    input wire logic cap_done_in,
    // visibility
    output win_mode_e window_mode,
    output logic probe_done
);

    // ============
    // input synchronisers
    localparam logic [7:0] SYNC_INIT = `SYNC_INIT;
    logic [7:0] raw;
    logic [7:0] meta;
    logic [7:0] sync;

    assign raw = {window_select_in, cap_done_in, lockout_ok, above_release,
                  below_threshold, link.service_kick_in, link.guard_enable,
                  link.manual_reset_n};

    // two flops per input, first one read only by the second
    for (genvar i = 0; i < 8; i++)
    begin : g_sync
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                meta[i] <= SYNC_INIT[i];
                sync[i] <= SYNC_INIT[i];
            end
            else
            begin
                meta[i] <= raw[i]; // R22
                sync[i] <= meta[i];
            end
        end
    end

    wire man_n = sync[0];
    wire guard = sync[1];
    wire kick = sync[2];
    wire supply_low = sync[3];
    wire supply_back = sync[4];
    wire lock_ok = sync[5];
    wire cap_done = sync[6];
    wire sel_high = sync[7];

    // edge detection on synchronised levels only
    logic kick_q;
    logic cap_q;
    wire kick_fall = kick_q & ~kick; // R10
    wire cap_rise = cap_done & ~cap_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            kick_q <= 1'b1;
            cap_q <= 1'b0;
        end
        else
        begin
            kick_q <= kick;
            cap_q <= cap_done;
        end
    end

    // ============
    // reset sequencer
    sup_state_e sup_state, next_sup_state;
    logic [31:0] sup_cnt, next_sup_cnt;

    always_comb
    begin
        next_sup_state = sup_state;
        next_sup_cnt = sup_cnt + 32'd1;
        case (sup_state)
            SUP_START:
            begin
                if (!lock_ok)
                    next_sup_cnt = 32'd0;
                else if (sup_cnt >= STARTUP_CYC - 1) // R17
                    next_sup_state = SUP_LOW;
            end
            SUP_LOW:
            begin
                next_sup_cnt = 32'd0;
                if (supply_back && !supply_low && man_n)
                    next_sup_state = SUP_HOLD;
            end
            SUP_HOLD:
            begin
                if (supply_low || !man_n) // R2 R3
                    next_sup_state = SUP_LOW;
                else if (sup_cnt >= HOLDOFF_CYC - 1) // R1
                    next_sup_state = SUP_RUN;
            end
            SUP_RUN:
            begin
                next_sup_cnt = 32'd0;
                if (supply_low || !man_n) // R2 R3
                    next_sup_state = SUP_LOW;
            end
            default:
            begin
                next_sup_state = SUP_START;
                next_sup_cnt = 32'd0;
            end
        endcase
        // losing the operating level restarts the power-up wait
        if (!lock_ok && sup_state != SUP_START)
        begin
            next_sup_state = SUP_START;
            next_sup_cnt = 32'd0;
        end
    end

    // reset pin is a registered open-drain low
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sup_state <= SUP_START;
            sup_cnt <= 32'd0;
            link.reset_oe <= 1'b1;
        end
        else
        begin
            sup_state <= next_sup_state;
            sup_cnt <= next_sup_cnt;
            link.reset_oe <= (next_sup_state != SUP_RUN); // R1 R2
        end
    end

    assign link.reset_o = 1'b0;
    wire entering_hold = (next_sup_state == SUP_HOLD) && (sup_state != SUP_HOLD);

    // ============
    // window select probe: discharge, release, classify
    probe_state_e pr_state, next_pr_state;
    logic [15:0] pr_cnt, next_pr_cnt;
    win_mode_e next_mode;

    always_comb
    begin
        next_pr_state = pr_state;
        next_pr_cnt = pr_cnt + 16'd1;
        next_mode = window_mode;
        case (pr_state)
            PR_IDLE, PR_DONE:
                next_pr_cnt = 16'd0;
            PR_DISCH:
            begin
                if (pr_cnt >= 16'(`DISCH_CYC - 1))
                    next_pr_state = PR_SENSE;
            end
            PR_SENSE:
            begin
                // a resistor pulls the pin up before any cap could charge
                if (pr_cnt == 16'(`DISCH_CYC + `SENSE_SAMPLE_CYC) && sel_high)
                begin
                    next_mode = MODE_RES;
                    next_pr_state = PR_DONE;
                end
                else if (cap_rise)
                begin
                    next_mode = MODE_CAP;
                    next_pr_state = PR_DONE;
                end
                else if (pr_cnt >= 16'(PROBE_CYC - 1)) // R16
                begin
                    next_mode = MODE_FLOAT;
                    next_pr_state = PR_DONE;
                end
            end
            default:
                next_pr_state = PR_IDLE;
        endcase
        // every reset release sequence re-probes the pin
        if (entering_hold) // R16
        begin
            next_pr_state = PR_DISCH;
            next_pr_cnt = 16'd0;
        end
    end

    // ============
    // window watchdog
    wd_state_e wd_state, next_wd_state;
    logic [31:0] wd_cnt, next_wd_cnt;
    logic [31:0] cap_len, next_cap_len;
    logic restart;

    wire wd_en = (sup_state == SUP_RUN) && guard && man_n; // R3 R4 R6 R8
    wire is_cap = (window_mode == MODE_CAP);
    wire [31:0] open_cyc = is_cap ? (cap_len >> 1) : // R21
        (window_mode == MODE_RES) ? RES_OPEN_CYC : FLOAT_OPEN_CYC; // R14 R15
    wire [31:0] close_cyc = (window_mode == MODE_RES) ? RES_CLOSE_CYC : FLOAT_CLOSE_CYC;
    wire close_hit = is_cap ? cap_rise : (wd_cnt >= close_cyc - 1); // R21

    always_comb
    begin
        next_wd_state = wd_state;
        next_wd_cnt = wd_cnt + 32'd1;
        next_cap_len = cap_len;
        restart = 1'b0;
        case (wd_state)
            WD_OFF:
            begin
                next_wd_cnt = 32'd0;
                if (wd_en)
                    next_wd_state = WD_SETTLE;
            end
            WD_SETTLE:
            begin
                if (wd_cnt >= 32'(`SETTLE_CYC - 1)) // R9
                begin
                    next_wd_state = WD_FIRST;
                    next_wd_cnt = 32'd0;
                    restart = 1'b1;
                end
            end
            WD_FIRST:
            begin
                if (kick_fall) // R12
                begin
                    next_wd_state = WD_WINDOW;
                    next_wd_cnt = 32'd0;
                    restart = 1'b1;
                end
                else if (close_hit) // R12
                begin
                    next_wd_state = WD_FAULT;
                    next_wd_cnt = 32'd0;
                end
            end
            WD_WINDOW:
            begin
                if (kick_fall)
                begin
                    next_wd_state = (wd_cnt < open_cyc) ? WD_FAULT : WD_WINDOW; // R13
                    next_wd_cnt = 32'd0;
                    restart = (wd_cnt >= open_cyc);
                end
                else if (close_hit) // R13
                begin
                    next_wd_state = WD_FAULT;
                    next_wd_cnt = 32'd0;
                end
            end
            WD_FAULT:
            begin
                // kicks are not looked at here
                if (wd_cnt >= HOLDOFF_CYC - 1) // R18 R20
                begin
                    next_wd_state = WD_FIRST;
                    next_wd_cnt = 32'd0;
                    restart = 1'b1;
                end
            end
            default:
                next_wd_state = WD_OFF;
        endcase
        // capacitor charge time sets the next open bound
        if (is_cap && cap_rise && (wd_state == WD_FIRST || wd_state == WD_WINDOW)) // R21
            next_cap_len = wd_cnt;
        if (!wd_en) // R4 R6 R19
        begin
            next_wd_state = WD_OFF;
            next_wd_cnt = 32'd0;
            restart = 1'b0;
        end
    end

    // state, flag pin and pin discharge drive
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pr_state <= PR_IDLE;
            pr_cnt <= 16'd0;
            window_mode <= MODE_FLOAT;
            wd_state <= WD_OFF;
            wd_cnt <= 32'd0;
            cap_len <= 32'd0;
            link.flag_oe <= 1'b0;
            window_select_oe <= 1'b0;
        end
        else
        begin
            pr_state <= next_pr_state;
            pr_cnt <= next_pr_cnt;
            window_mode <= next_mode;
            wd_state <= next_wd_state;
            wd_cnt <= next_wd_cnt;
            cap_len <= next_cap_len;
            link.flag_oe <= (next_wd_state == WD_FAULT); // R7 R18 R19
            // one-cycle discharge restarts the timing cap each window
            window_select_oe <= (next_pr_state == PR_DISCH) || (restart && is_cap);
        end
    end

    assign link.flag_o = 1'b0;
    assign window_select_out = 1'b0;
    assign probe_done = (pr_state == PR_DONE);

endmodule

// >>> src/supervisor_host.sv
// host end: AHB-Lite register slave that drives the supervisor pins
// assumes the device runs on the same hclk, so its lines need no synchroniser
`timescale 1ns/1ps
`include "supervisor_regs.svh"
module supervisor_host
    import supervisor_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // pins to the supervisor
    supervisor_if.host link
);

    // ============
    // address phase capture
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_addr;
    logic [1:0] ctrl;
    logic [4:0] hold_cnt;
    logic [1:0] kick_cnt;

    wire addr_ok = hsel && htrans[1] && hready && (hsize == 3'b010);
    wire ctrl_wr = ph_valid && ph_write && (ph_addr == `CTRL_OFS);
    wire kick_wr = ph_valid && ph_write && (ph_addr == `KICK_OFS);
    // a control change waits until the previous level has stood long enough
    wire stall = ctrl_wr && (hold_cnt != 5'd0); // R5
    wire ctrl_take = ctrl_wr && !stall;
    wire ctrl_change = ctrl_take && (hwdata[1:0] != ctrl);
    wire kick_go = kick_wr && hwdata[`KICK_GO_BIT] && (kick_cnt == 2'd0);
    wire [31:0] stat = {28'd0, (hold_cnt != 5'd0), (kick_cnt != 2'd0),
                        link.timeout_flag_n, link.reset_line};
    wire [31:0] rd_mux = (haddr[7:0] == `CTRL_OFS) ? {30'd0, ctrl} :
                         (haddr[7:0] == `STAT_OFS) ? stat : 32'd0;

    assign hreadyout = !stall;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
        end
        else if (hready)
        begin
            ph_valid <= addr_ok;
            ph_write <= hwrite;
            ph_addr <= haddr[7:0];
            if (addr_ok && !hwrite)
                hrdata <= rd_mux;
        end
    end

    // ============
    // control levels with minimum hold time
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl <= `CTRL_RST;
            hold_cnt <= 5'd0;
        end
        else
        begin
            if (ctrl_take)
                ctrl <= hwdata[1:0];
            if (ctrl_change)
                hold_cnt <= 5'(`LEVEL_HOLD_CYC); // R5
            else if (hold_cnt != 5'd0)
                hold_cnt <= hold_cnt - 5'd1;
        end
    end

    // ============
    // kick pulse: low for a fixed width, falling edge is the service
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            kick_cnt <= 2'd0;
            link.service_kick_in <= 1'b1;
            link.manual_reset_n <= 1'b1;
            link.guard_enable <= 1'b0;
        end
        else
        begin
            if (kick_go)
                kick_cnt <= 2'(`KICK_LOW_CYC); // R11
            else if (kick_cnt != 2'd0)
                kick_cnt <= kick_cnt - 2'd1;
            link.service_kick_in <= !(kick_go || kick_cnt > 2'd1); // R10 R11
            link.manual_reset_n <= !ctrl[`CTRL_MAN_BIT]; // R3
            link.guard_enable <= ctrl[`CTRL_EN_BIT]; // R8
        end
    end

endmodule

// >>> test/supervisor_monitor.sv
// checker for the supervisor pins between host end and device end
// assumes plain inputs wired to the interface, one hclk domain
`timescale 1ns/1ps
module supervisor_monitor #(
    parameter int unsigned HOLDOFF_CYC = 200
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // host driven levels
    input wire logic manual_reset_n,
    input wire logic guard_enable,
    input wire logic service_kick_in,
    // device open-drain enables
    input wire logic reset_oe,
    input wire logic flag_oe
);
    // ============
    // helper counters
    localparam int HOLD_GAP = 24; // 25 cycles held means 24 counted edges
    logic [31:0] rst_cnt;
    logic [31:0] flag_cnt;
    logic [7:0] lvl_gap;
    logic [1:0] lvl_prev;
    wire lvl_moved = {manual_reset_n, guard_enable} != lvl_prev;
    wire [7:0] next_gap = lvl_moved ? 8'h00 : (lvl_gap == 8'hff ? lvl_gap : lvl_gap + 8'h01);

    // run lengths of each enable, gap since last level change (saturates)
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rst_cnt <= 32'h0;
            flag_cnt <= 32'h0;
            lvl_gap <= 8'hff;
            lvl_prev <= 2'h2;
        end
        else
        begin
            rst_cnt <= reset_oe ? rst_cnt + 32'h1 : 32'h0;
            flag_cnt <= flag_oe ? flag_cnt + 32'h1 : 32'h0;
            lvl_gap <= next_gap;
            lvl_prev <= {manual_reset_n, guard_enable};
        end
    end

    // ============
    // properties
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_kick_low;
        !service_kick_in ##1 service_kick_in;
    endsequence
    sequence s_reset_held;
        reset_oe [*3];
    endsequence
    property p_kick_pulse;
        $fell(service_kick_in) |=> s_kick_low;
    endproperty
    property p_reset_holdoff;
        $fell(reset_oe) |-> rst_cnt >= HOLDOFF_CYC;
    endproperty
    // guard or manual loss ends the flag early, so those are excluded
    property p_flag_len;
        $fell(flag_oe) && !reset_oe && manual_reset_n && guard_enable
            |-> flag_cnt == HOLDOFF_CYC;
    endproperty
    property p_flag_in_reset;
        s_reset_held |-> !flag_oe;
    endproperty
    property p_flag_cause;
        $rose(flag_oe) |-> guard_enable && manual_reset_n && !reset_oe;
    endproperty
    property p_guard_off;
        !guard_enable [*6] |-> !flag_oe;
    endproperty
    property p_manual;
        !manual_reset_n [*6] |-> reset_oe;
    endproperty
    property p_level_gap;
        lvl_moved |-> lvl_gap >= HOLD_GAP;
    endproperty

    a_kick_pulse: assert property (p_kick_pulse) else $error("kick pulse width");
    a_reset_holdoff: assert property (p_reset_holdoff) else $error("reset short");
    a_flag_len: assert property (p_flag_len) else $error("flag length");
    a_flag_in_reset: assert property (p_flag_in_reset) else $error("flag in reset");
    a_flag_cause: assert property (p_flag_cause) else $error("flag while off");
    a_guard_off: assert property (p_guard_off) else $error("flag with guard low");
    a_manual: assert property (p_manual) else $error("manual ignored");
    a_level_gap: assert property (p_level_gap) else $error("level held short");
endmodule

// >>> test/tb_top.sv
// bench: host end and device end joined by the pin interface
// assumes shortened hold-off and window counts so the run stays short
`timescale 1ns/1ps
`include "supervisor_regs.svh"
module tb_top
    import supervisor_pkg::*;
();
    localparam int HOLDOFF = 200;
    localparam int STARTUP = 50;
    localparam int FL_OPEN = 100;
    localparam int FL_CLOSE = 200;
    localparam int RES_OPEN = 40;
    localparam int RES_CLOSE = 120;
    localparam int SETTLE = `SETTLE_CYC;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic below_threshold = 1'b0;
    logic above_release = 1'b1;
    logic lockout_ok = 1'b1;
    logic sel_pull = 1'b0;
    logic hreadyout, sel_oe, probe_done, flag_seen;
    logic [31:0] hrdata, rd_snap;
    logic [31:0] seed = 32'h46;
    win_mode_e window_mode;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    // select pin: device discharge wins over the pull
    wire window_select_in = sel_oe ? 1'b0 : sel_pull;

    supervisor_if link();
    supervisor_dev #(.HOLDOFF_CYC(HOLDOFF), .STARTUP_CYC(STARTUP), .PROBE_CYC(60),
        .FLOAT_OPEN_CYC(FL_OPEN), .FLOAT_CLOSE_CYC(FL_CLOSE), .RES_OPEN_CYC(RES_OPEN),
        .RES_CLOSE_CYC(RES_CLOSE)) supervisor_dev_inst (.hclk, .hresetn, .link(link.dev),
        .below_threshold, .above_release, .lockout_ok, .window_select_in,
        .window_select_out(), .window_select_oe(sel_oe), .cap_done_in(1'b0), .window_mode,
        .probe_done);
    supervisor_host supervisor_host_inst (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp(),
        .link(link.host));
    supervisor_monitor #(.HOLDOFF_CYC(HOLDOFF)) supervisor_monitor_inst (.hclk, .hresetn,
        .manual_reset_n(link.manual_reset_n),
        .guard_enable(link.guard_enable), .service_kick_in(link.service_kick_in),
        .reset_oe(link.reset_oe), .flag_oe(link.flag_oe));

    // ============
    // clock, hang guard, flag latch
    always #20 hclk = ~hclk;
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            miscompares++;
            complete_run();
        end
    end
    always @(negedge hclk)
        if (link.timeout_flag_n === 1'b0)
            flag_seen = 1'b1;

    // ============
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int n, input int lo, input int hi);
        compares++;
        if (n < lo || n > hi)
        begin
            miscompares++;
            $display("wrong value at %0t: %0d cycles outside %0d..%0d", $time, n, lo, hi);
        end
    endtask
    // ready judged at the fall, as the next rise samples it
    task automatic wait_rdy();
        @(negedge hclk);
        while (hreadyout !== 1'b1)
            @(negedge hclk);
        rd_snap = hrdata;
        @(posedge hclk);
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge hclk);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = rd_snap;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] t;
        ahb(1'b1, a, d, t);
    endtask
    task automatic kick();
        wr(`KICK_OFS, 32'h1);
    endtask
    task automatic wait_lvl(input bit flag, input logic lvl, output int n);
        n = 0;
        @(negedge hclk);
        while (((flag ? link.timeout_flag_n : link.reset_line) !== lvl) && n < 9000)
        begin
            @(negedge hclk);
            n++;
        end
    endtask
    // kick spacing is the gap plus about 12 bus cycles
    task automatic run_gaps(input int open, input int close);
        int gaps[$];
        kick();
        repeat (3) gaps.push_back(open + int'(rnd() % (close - open - 30)));
        gaps.push_back(5);
        flag_seen = 1'b0;
        foreach (gaps[i])
        begin
            repeat (gaps[i]) @(posedge hclk);
            kick();
            repeat (8) @(posedge hclk);
            chk(flag_seen, ((gaps[i] + 12) < open) || ((gaps[i] + 12) >= close));
        end
    endtask
    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ============
    // main sequence
    initial
    begin
        int n;
        logic [31:0] r;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        wait_lvl(0, 1'b1, n);
        chk_rng(n, STARTUP + HOLDOFF, STARTUP + HOLDOFF + 10);
        chk(window_mode, MODE_FLOAT);
        chk(probe_done, 1'b1);
        ahb(1'b0, `STAT_OFS, 32'h0, r);
        chk(r & 32'h3, 32'h3);
        ahb(1'b0, 8'h40, 32'h0, r);
        chk(r, 32'h0);
        wr(`CTRL_OFS, 32'h2);
        kick();
        wait_lvl(1, 1'b0, n);
        chk_rng(n, SETTLE + FL_CLOSE - 12, SETTLE + FL_CLOSE + 4);
        fork
            kick();
            wait_lvl(1, 1'b1, n);
        join
        chk(n + 1, HOLDOFF);
        run_gaps(FL_OPEN, FL_CLOSE);
        wr(`CTRL_OFS, 32'h0);
        wait_lvl(1, 1'b1, n);
        chk_rng(n, 0, 8);
        flag_seen = 1'b0;
        repeat (3 * FL_CLOSE) @(posedge hclk);
        chk(flag_seen, 32'h0);
        wr(`CTRL_OFS, 32'h2);
        wait_lvl(1, 1'b0, n);
        wr(`CTRL_OFS, 32'h3);
        wait_lvl(0, 1'b0, n);
        chk_rng(n, 0, 8);
        ahb(1'b0, `STAT_OFS, 32'h0, r);
        chk(r & 32'h3, 32'h2);
        wr(`CTRL_OFS, 32'h2);
        wait_lvl(0, 1'b1, n);
        chk_rng(n, HOLDOFF, HOLDOFF + 10);
        @(posedge hclk);
        sel_pull <= 1'b1;
        below_threshold <= 1'b1;
        above_release <= 1'b0;
        wait_lvl(0, 1'b0, n);
        chk_rng(n, 0, 6);
        @(posedge hclk);
        below_threshold <= 1'b0;
        above_release <= 1'b1;
        wait_lvl(0, 1'b1, n);
        chk_rng(n, HOLDOFF, HOLDOFF + 8);
        chk(window_mode, MODE_RES);
        wait_lvl(1, 1'b0, n);
        chk_rng(n, SETTLE + RES_CLOSE - 2, SETTLE + RES_CLOSE + 6);
        wait_lvl(1, 1'b1, n);
        run_gaps(RES_OPEN, RES_CLOSE);
        complete_run();
    end
endmodule
